/* File: hw/gpio_fgh_pkg.sv */
// Package of constants and carrier types for the three-port GPIO block.
// Assumes an APB slave with 32-bit data; registers take one aligned word.
//
// Functional notes
// - Eight-pin port has one data latch per pin; reset leaves latches alone.
// - Direction bit 1 enables the pin's output buffer; 0 makes it input.
// - Reset clears all direction bits of all three ports.
// - Eight-pin data read gives latch for outputs, pin level for inputs.
// - Data latch writes with byte strobe 0 set always land; input pins read back unchanged.
// - Timer-owned pins ignore direction for drive, not for read select.
// - Six pins go to timer or GPIO by the timer edge/level select field.
// - Pull-up enable bit 1 connects the pin pull-up, 0 disconnects it.
// - Pull-up applies only while the pin's direction bit is 0, even if the timer drives it.
// - Three-pin port has three latch and direction bits, same read rule.
// - Keyboard enable bits 2..0 make three-pin port pins interrupt inputs.
// - Two-pin port has two latch and direction bits, same read rule.
// - Keyboard enable bits 4..3 make two-pin port pins interrupt inputs.

package gpio_fgh_pkg;

  // ****************************************************************
  // Register indices, widths and reset values
  // ****************************************************************
  localparam logic [7:0] F_LATCH_IDX   = 8'h09;
  localparam logic [7:0] G_LATCH_IDX   = 8'h0A;
  localparam logic [7:0] H_LATCH_IDX   = 8'h0B;
  localparam logic [7:0] F_DIR_IDX     = 8'h0C;
  localparam logic [7:0] G_DIR_IDX     = 8'h0D;
  localparam logic [7:0] H_DIR_IDX     = 8'h0E;
  localparam logic [7:0] F_PULLUP_IDX  = 8'h0F;
  localparam int         ADDR_W        = 12;
  localparam int         F_W           = 8;
  localparam int         G_W           = 3;
  localparam int         H_W           = 2;
  localparam int         TIMER_PINS    = 6;
  localparam int         KBD_W         = 5;
  localparam logic [7:0] DIR_RESET     = 8'h00;
  localparam logic [7:0] PULLUP_RESET  = 8'h00;
  localparam logic [1:0] ELS_GPIO      = 2'h0;
  localparam int         KBD_G_LSB     = 0;
  localparam int         KBD_H_LSB     = 3;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [F_W-1:0] f;
    logic [G_W-1:0] g;
    logic [H_W-1:0] h;
  } pins_s;

endpackage

/* File: hw/gpio_ports_f_g_h.sv */
// GPIO logic for an eight-pin, a three-pin and a two-pin port.
// Assumes APB master with 32-bit data and pins synchronous to MCLK.
`timescale 1ns/10ps
`default_nettype none

module gpio_ports_f_g_h
(
  // Clock and reset
  input  wire logic                                 MCLK,
  input  wire logic                                 SYS_RST,
  // APB slave
  input  wire logic                                 PSEL,
  input  wire logic                                 PENABLE,
  input  wire logic                                 PWRITE,
  input  wire logic [gpio_fgh_pkg::ADDR_W-1:0]      PADDR,
  input  wire logic [31:0]                          PWDATA,
  input  wire logic [3:0]                           PSTRB,
  output logic      [31:0]                          PRDATA,
  output logic                                      PREADY,
  output logic                                      PSLVERR,
  // Pins
  input  wire gpio_fgh_pkg::pins_s                  PIN_IN,
  output gpio_fgh_pkg::pins_s                       PIN_OUT,
  output gpio_fgh_pkg::pins_s                       PIN_OE,
  output logic      [gpio_fgh_pkg::F_W-1:0]         F_PULLUP_ON,
  // Timer channels on eight-pin port bits 5..0
  input  wire logic [2*gpio_fgh_pkg::TIMER_PINS-1:0] TIMER_ELS,
  input  wire logic [gpio_fgh_pkg::TIMER_PINS-1:0]  TIMER_OUT,
  input  wire logic [gpio_fgh_pkg::TIMER_PINS-1:0]  TIMER_OE,
  output logic      [gpio_fgh_pkg::TIMER_PINS-1:0]  TIMER_IN,
  // Keyboard interrupt module
  input  wire logic [gpio_fgh_pkg::KBD_W-1:0]       KBD_ENABLE,
  output logic      [gpio_fgh_pkg::KBD_W-1:0]       KBD_PIN_LEVEL
);

  localparam int FW = gpio_fgh_pkg::F_W;
  localparam int GW = gpio_fgh_pkg::G_W;
  localparam int HW = gpio_fgh_pkg::H_W;
  localparam int TP = gpio_fgh_pkg::TIMER_PINS;
  localparam int ADDR_W_TOP = gpio_fgh_pkg::ADDR_W - 1;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [FW-1:0]       f_latch_q;
  logic [GW-1:0]       g_latch_q;
  logic [HW-1:0]       h_latch_q;
  logic [FW-1:0]       f_dir_q;
  logic [GW-1:0]       g_dir_q;
  logic [HW-1:0]       h_dir_q;
  logic [FW-1:0]       f_pullup_q;
  gpio_fgh_pkg::pins_s pin_q;
  logic [TP-1:0]       timer_own;
  logic                wr_en;
  logic                rd_en;
  logic                hit;
  logic [7:0]          reg_idx;
  logic [31:0]         rd_d;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Word index is the byte address over four; the low two bits are ignored.
  assign reg_idx = PADDR[9:2];
  assign wr_en   = PSEL && !PENABLE && PWRITE && hit && PSTRB[0];
  assign rd_en   = PSEL && !PENABLE && !PWRITE;

  always_comb
  begin
    hit = 1'b1;
    case (reg_idx)
      gpio_fgh_pkg::F_LATCH_IDX,
      gpio_fgh_pkg::G_LATCH_IDX,
      gpio_fgh_pkg::H_LATCH_IDX,
      gpio_fgh_pkg::F_DIR_IDX,
      gpio_fgh_pkg::G_DIR_IDX,
      gpio_fgh_pkg::H_DIR_IDX,
      gpio_fgh_pkg::F_PULLUP_IDX: hit = (PADDR[ADDR_W_TOP:10] == '0);
      default:                    hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  // One register stage on the pins; inputs are taken as synchronous.
  always_ff @(posedge MCLK)
  begin
    pin_q <= PIN_IN;
  end

  // ****************************************************************
  // Data latches
  // ****************************************************************
  // No reset here: the latches keep their contents through reset, and
  // any write with PSTRB[0] set lands whatever the direction.
  always_ff @(posedge MCLK)
  begin
    if (wr_en && reg_idx == gpio_fgh_pkg::F_LATCH_IDX)
      f_latch_q <= PWDATA[FW-1:0];
    if (wr_en && reg_idx == gpio_fgh_pkg::G_LATCH_IDX)
      g_latch_q <= PWDATA[GW-1:0];
    if (wr_en && reg_idx == gpio_fgh_pkg::H_LATCH_IDX)
      h_latch_q <= PWDATA[HW-1:0];
  end

  // ****************************************************************
  // Direction registers
  // ****************************************************************
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      f_dir_q <= gpio_fgh_pkg::DIR_RESET[FW-1:0];
      g_dir_q <= gpio_fgh_pkg::DIR_RESET[GW-1:0];
      h_dir_q <= gpio_fgh_pkg::DIR_RESET[HW-1:0];
    end
    else
    begin
      if (wr_en && reg_idx == gpio_fgh_pkg::F_DIR_IDX)
        f_dir_q <= PWDATA[FW-1:0];
      if (wr_en && reg_idx == gpio_fgh_pkg::G_DIR_IDX)
        g_dir_q <= PWDATA[GW-1:0];
      if (wr_en && reg_idx == gpio_fgh_pkg::H_DIR_IDX)
        h_dir_q <= PWDATA[HW-1:0];
    end
  end

  // ****************************************************************
  // Pull-up enables
  // ****************************************************************
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      f_pullup_q <= gpio_fgh_pkg::PULLUP_RESET[FW-1:0];
    else if (wr_en && reg_idx == gpio_fgh_pkg::F_PULLUP_IDX)
      f_pullup_q <= PWDATA[FW-1:0];
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // A channel owns its pin whenever its edge/level field is not zero.
  genvar t;
  generate
    for (t = 0; t < TP; t++)
    begin : g_own
      assign timer_own[t] =
        (TIMER_ELS[2*t+1:2*t] != gpio_fgh_pkg::ELS_GPIO);
    end
  endgenerate

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      PIN_OE  <= '0;
      PIN_OUT <= '0;
    end
    else
    begin
      for (int i = 0; i < FW; i++)
      begin
        if (i < TP && timer_own[i])
        begin
          PIN_OE.f[i]  <= TIMER_OE[i];
          PIN_OUT.f[i] <= TIMER_OUT[i];
        end
        else
        begin
          PIN_OE.f[i]  <= f_dir_q[i];
          PIN_OUT.f[i] <= f_latch_q[i];
        end
      end
      PIN_OE.g  <= g_dir_q;
      PIN_OUT.g <= g_latch_q;
      PIN_OE.h  <= h_dir_q;
      PIN_OUT.h <= h_latch_q;
    end
  end

  // Pull-up is cut while the direction bit is 1; a timer-driven pin with direction 0 keeps it.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      F_PULLUP_ON <= '0;
    else
      F_PULLUP_ON <= f_pullup_q & ~f_dir_q;
  end

  // ****************************************************************
  // Peripheral input paths
  // ****************************************************************
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      TIMER_IN      <= '0;
      KBD_PIN_LEVEL <= '0;
    end
    else
    begin
      TIMER_IN <= pin_q.f[TP-1:0] & timer_own;
      // Keyboard inputs see the level only where their enable is set.
      KBD_PIN_LEVEL[GW-1:0] <=
        pin_q.g & KBD_ENABLE[gpio_fgh_pkg::KBD_G_LSB +: GW];
      KBD_PIN_LEVEL[gpio_fgh_pkg::KBD_W-1:GW] <=
        pin_q.h & KBD_ENABLE[gpio_fgh_pkg::KBD_H_LSB +: HW];
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (reg_idx)
      gpio_fgh_pkg::F_LATCH_IDX:
        rd_d[FW-1:0] = (f_dir_q & f_latch_q) | (~f_dir_q & pin_q.f);
      gpio_fgh_pkg::G_LATCH_IDX:
        rd_d[GW-1:0] = (g_dir_q & g_latch_q) | (~g_dir_q & pin_q.g);
      gpio_fgh_pkg::H_LATCH_IDX:
        rd_d[HW-1:0] = (h_dir_q & h_latch_q) | (~h_dir_q & pin_q.h);
      gpio_fgh_pkg::F_DIR_IDX:    rd_d[FW-1:0] = f_dir_q;
      gpio_fgh_pkg::G_DIR_IDX:    rd_d[GW-1:0] = g_dir_q;
      gpio_fgh_pkg::H_DIR_IDX:    rd_d[HW-1:0] = h_dir_q;
      gpio_fgh_pkg::F_PULLUP_IDX: rd_d[FW-1:0] = f_pullup_q;
      default:                    rd_d = 32'h0000_0000;
    endcase
    if (!hit)
      rd_d = 32'h0000_0000;
  end

  // Answer registered in the setup cycle, so every access has no wait.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
    else
    begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit;
      if (rd_en)
        PRDATA <= rd_d;
    end
  end

endmodule

`default_nettype wire

/* File: testbench/gpio_fgh_monitor.sv */
// Port-level checks for the three-port GPIO block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module gpio_fgh_monitor
(
  // Clock, reset and bus
  input wire logic                MCLK,
  input wire logic                SYS_RST,
  input wire logic                PSEL,
  input wire logic                PENABLE,
  input wire logic                PWRITE,
  input wire logic [11:0]         PADDR,
  input wire logic [31:0]         PWDATA,
  input wire logic [3:0]          PSTRB,
  input wire logic                PREADY,
  input wire logic                PSLVERR,
  // Pins and shared modules
  input wire gpio_fgh_pkg::pins_s PIN_OE,
  input wire logic [7:0]          F_PULLUP_ON,
  input wire logic [11:0]         TIMER_ELS,
  input wire logic [5:0]          TIMER_OE,
  input wire logic [5:0]          TIMER_IN,
  input wire logic [4:0]          KBD_ENABLE,
  input wire logic [4:0]          KBD_PIN_LEVEL
);
  logic [5:0] owned;

  always_comb
    for (int t = 0; t < 6; t++)
      owned[t] = |TIMER_ELS[2*t +: 2];

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  a_ready_follows: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_dir_reset: assert property ($fell(SYS_RST) |->
    PIN_OE == 13'h0000 && F_PULLUP_ON == 8'h00)
    else $error("outputs enabled after reset");
  a_pull_gated: assert property ((F_PULLUP_ON[7:6] & PIN_OE.f[7:6])
    == 2'h0) else $error("pull-up on a driven pin");
  a_dir_write: assert property (PSEL && !PENABLE && PWRITE &&
    PSTRB[0] && PADDR == 12'h034 |-> ##2 PIN_OE.g == $past(PWDATA[2:0], 2))
    else $error("direction write not on drive enable");
  a_kbd_gate: assert property ((KBD_PIN_LEVEL & ~$past(KBD_ENABLE))
    == 5'h00) else $error("keyboard level on disabled pin");
  a_timer_gate: assert property ((TIMER_IN & ~$past(owned)) == 6'h00)
    else $error("timer input on unowned pin");
  a_timer_drive: assert property ((PIN_OE.f[5:0] & $past(owned)) ==
    $past(TIMER_OE & owned)) else $error("timer drive not followed");
endmodule

bind gpio_ports_f_g_h gpio_fgh_monitor gpio_fgh_monitor_inst
(
  .MCLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
  .PREADY, .PSLVERR, .PIN_OE, .F_PULLUP_ON, .TIMER_ELS, .TIMER_OE,
  .TIMER_IN, .KBD_ENABLE, .KBD_PIN_LEVEL
);
`default_nettype wire

/* File: testbench/pin_world.sv */
// Pad model: each pad level from drive, pull-up and the outside level.
// Assumes the bench sets the outside level of every undriven pad.
`timescale 1ns/10ps
`default_nettype none

module pin_world
(
  // Pads
  input  wire gpio_fgh_pkg::pins_s drv,
  input  wire gpio_fgh_pkg::pins_s oe,
  input  wire gpio_fgh_pkg::pins_s ext,
  input  wire logic [7:0]          pull,
  output gpio_fgh_pkg::pins_s      lvl
);
  // A connected pull-up wins over a low outside level here on purpose.
  assign lvl = (drv & oe) | (ext & ~oe) | {pull & ~oe.f, 5'h00};
endmodule
`default_nettype wire

/* File: testbench/tb_gpio_ports_f_g_h.sv */
// Self-checking bench for the three-port GPIO block.
// Assumes the pad model and the bound monitor are compiled alongside.
`timescale 1ns/10ps
`default_nettype none

module tb_gpio_ports_f_g_h;
  localparam logic [11:0] AF = 12'h024, AG = 12'h028, AH = 12'h02C;
  localparam logic [11:0] DF = 12'h030, DG = 12'h034, DH = 12'h038;
  localparam logic [11:0] PU = 12'h03C;
  logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic er, pready, pslverr;
  logic [11:0] paddr = 0, els = 0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] pull;
  logic [5:0] tout = 0, toe = 0, tin;
  logic [4:0] ken = 0, klv;
  gpio_fgh_pkg::pins_s ext = 13'h0000, lvl, drv, oe;
  int errors = 0;
  int n_tests = 0;

  always #2 mclk = ~mclk;

  gpio_ports_f_g_h gpio_ports_f_g_h_inst
  (
    .MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(lvl),
    .PIN_OUT(drv), .PIN_OE(oe), .F_PULLUP_ON(pull), .TIMER_ELS(els),
    .TIMER_OUT(tout), .TIMER_OE(toe), .TIMER_IN(tin), .KBD_ENABLE(ken),
    .KBD_PIN_LEVEL(klv)
  );

  pin_world pin_world_inst
  (
    .drv(drv), .oe(oe), .ext(ext), .pull(pull), .lvl(lvl)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, got);
    n_tests++;
    if (got !== e)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        errors++;
        end_of_test();
      end
      @(posedge mclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [11:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask

  task automatic t_port_f();
    ext.f <= 8'h3C;
    apb(1'b1, AF, 32'hA5);
    rdchk("f input read", AF, 32'h3C);
    apb(1'b1, DF, 32'hF0);
    apb(1'b1, PU, 32'hFF);
    ext.f <= 8'h00;
    rdchk("f mixed read", AF, 32'hAF);
    chk("f enables", 32'hF0, oe.f);
    chk("f pull-ups", 32'h0F, pull);
    $display("port f test done");
  endtask

  task automatic t_port_gh();
    ext.g <= 3'h6;
    ext.h <= 2'h1;
    apb(1'b1, AG, 32'h2);
    apb(1'b1, DG, 32'h3);
    apb(1'b1, AH, 32'h1);
    apb(1'b1, DH, 32'h2);
    rdchk("g read", AG, 32'h6);
    rdchk("h read", AH, 32'h1);
    rdchk("g direction", DG, 32'h3);
    chk("h enables", 32'h2, oe.h);
    ken <= 5'h1B;
    repeat (4) @(posedge mclk);
    chk("keyboard levels", 32'h0A, klv);
    $display("ports g h test done");
  endtask

  task automatic t_timer();
    els <= 12'h001;
    toe <= 6'h01;
    tout <= 6'h01;
    repeat (4) @(posedge mclk);
    chk("timer drive", 32'h1, oe.f[0]);
    rdchk("timer pin read", AF, 32'hAF);
    chk("timer input", 32'h1, tin);
    els <= 12'h000;
    toe <= 6'h00;
    tout <= 6'h00;
    $display("timer test done");
  endtask

  task automatic t_errors_reset();
    apb(1'b1, 12'h040, 32'hFF);
    chk("unmapped write", 32'h1, er);
    rdchk("unmapped read", 12'h040, 32'h0);
    chk("unmapped read err", 32'h1, er);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rdchk("dir after reset", DF, 32'h0);
    rdchk("h dir after reset", DH, 32'h0);
    apb(1'b1, DF, 32'hFF);
    pstrb <= 4'h0;
    apb(1'b1, AF, 32'h00);
    pstrb <= 4'hF;
    rdchk("latch kept", AF, 32'hA5);
    $display("error and reset test done");
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    chk("enables at reset", 32'h0, oe);
    rdchk("g dir at reset", DG, 32'h0);
    t_port_f();
    t_port_gh();
    t_timer();
    t_errors_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
